// File: src/wic_ctrl.sv
// wake-up, priority, vector and power-mode control top
`include "wic_params.svh"
`default_nettype none
module wic_ctrl (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [`WIC_AW-1:0] reg_addr_i,
  input wire logic [`WIC_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`WIC_DW-1:0] reg_rdata_o,
  input wire logic [7:0] ext_edge_line_i,
  input wire logic [7:0] pin_dir_i,
  input wire logic [`WIC_NPER-1:0] per_flag_i,
  input wire logic [`WIC_NPER-1:0] per_en_i,
  input wire logic [`WIC_NPER-1:0] per_clr_i,
  input wire logic trap_op_i,
  input wire logic halt_op_i,
  input wire logic sleep_until_event_op_i,
  input wire logic return_from_handler_op_i,
  input wire logic instr_end_i,
  output logic irq_take_o,
  output logic [15:0] irq_vec_o,
  output logic mask_flag_o,
  output logic cpu_stall_o,
  output logic osc_run_o,
  output logic core_tick_o,
  output wic_pkg::wic_mode_e mode_o
);
  logic [7:0] edge_line_enable_reg;
  logic trap_lat;
  logic ext_lat;
  logic ext_edge;
  logic [`WIC_NPER-1:0] per_lat;
  logic [`WIC_NPER-1:0] per_flag_q;
  logic [`WIC_NPER-1:0] per_rise;
  logic [`WIC_NPER-1:0] per_act;
  logic [`WIC_DIV_W-1:0] div_cnt;
  logic [`WIC_STAB_W-1:0] stab_cnt;
  logic ext_act;
  logic any_req;
  logic halt_wake;
  logic stab_done;
  logic go_halt;
  logic go_sleep;
  logic take_now;
  logic [15:0] pick_vec;
  wic_pkg::wic_mode_e next_mode;

  // vector of the highest-priority active source; reset sits above all
  function automatic logic [15:0] wic_pick(
    input logic trap,
    input logic ext,
    input logic [`WIC_NPER-1:0] per
  );
    logic [15:0] v;
    v = `WIC_VEC_USB;
    if (trap) begin
      v = `WIC_VEC_TRAP;
    end else if (per[`WIC_SRC_USBES]) begin
      v = `WIC_VEC_USBES;
    end else if (ext) begin
      v = `WIC_VEC_EXT;
    end else if (per[`WIC_SRC_TIMER]) begin
      v = `WIC_VEC_TIMER;
    end else if (per[`WIC_SRC_TWI]) begin
      v = `WIC_VEC_TWI;
    end else if (per[`WIC_SRC_SCI]) begin
      v = `WIC_VEC_SCI;
    end
    return v;
  endfunction : wic_pick

  // pin edge detection, gated by enable and direction
  wic_edge u_edge (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .pin_i(ext_edge_line_i),
    .dir_i(pin_dir_i),
    .en_i(edge_line_enable_reg),
    .edge_o(ext_edge)
  );

  // request qualification; the mask flag gates all but the trap
  always_comb begin
    per_rise = per_flag_i & ~per_flag_q;
    per_act = per_lat & per_en_i & {`WIC_NPER{~mask_flag_o}};
    ext_act = ext_lat & ~mask_flag_o;
    any_req = trap_lat | ext_act | (|per_act);
    // halt ends only through the external group or usb end-suspend
    halt_wake = ext_act | (|(per_act & `WIC_HALT_PER_MASK));
    stab_done = (mode_o == wic_pkg::WIC_START) && core_tick_o &&
                (stab_cnt == `WIC_STAB_LAST);
    go_halt = (mode_o == wic_pkg::WIC_RUN) && halt_op_i;
    go_sleep = (mode_o == wic_pkg::WIC_RUN) && sleep_until_event_op_i &&
               !halt_op_i;
    // service at an instruction boundary, on a wait wake or after start-up
    take_now = any_req && !go_halt && !go_sleep &&
               (((mode_o == wic_pkg::WIC_RUN) && instr_end_i) ||
                (mode_o == wic_pkg::WIC_WAIT) || stab_done);
    pick_vec = wic_pick(trap_lat, ext_act, per_act);
  end

  // power mode sequencing
  always_comb begin
    next_mode = mode_o;
    case (mode_o)
      wic_pkg::WIC_RUN: begin
        if (go_halt) begin
          next_mode = wic_pkg::WIC_HALT;
        end else if (go_sleep) begin
          next_mode = wic_pkg::WIC_WAIT;
        end
      end
      wic_pkg::WIC_WAIT: begin
        if (any_req) begin
          next_mode = wic_pkg::WIC_RUN;
        end
      end
      wic_pkg::WIC_HALT: begin
        if (halt_wake) begin
          next_mode = wic_pkg::WIC_START;
        end
      end
      wic_pkg::WIC_START: begin
        if (stab_done) begin
          next_mode = wic_pkg::WIC_RUN;
        end
      end
      default: begin
        next_mode = wic_pkg::WIC_RUN;
      end
    endcase
  end

  // mode register and cpu hold; reset always lands in run
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mode_o <= wic_pkg::WIC_RUN;
      cpu_stall_o <= 1'b0;
    end else if (ce_i) begin
      mode_o <= next_mode;
      cpu_stall_o <= (next_mode != wic_pkg::WIC_RUN);
    end
  end

  // oscillator enable: off in halt, back on at the wake event
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      osc_run_o <= 1'b1;
    end else if (ce_i) begin
      if (go_halt) begin
        osc_run_o <= 1'b0;
      end else if ((mode_o == wic_pkg::WIC_HALT) && halt_wake) begin
        osc_run_o <= 1'b1;
      end
    end
  end

  // divide by 3 core tick; stands still with the oscillator
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      div_cnt <= `WIC_DIV_ZERO;
      core_tick_o <= 1'b0;
    end else if (ce_i) begin
      if (!osc_run_o || (div_cnt == `WIC_DIV_LAST)) begin
        div_cnt <= `WIC_DIV_ZERO;
      end else begin
        div_cnt <= div_cnt + `WIC_DIV_ONE;
      end
      core_tick_o <= osc_run_o && (div_cnt == `WIC_DIV_LAST);
    end
  end

  // stabilisation counter in core ticks, not raw clocks
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      stab_cnt <= `WIC_STAB_ZERO;
    end else if (ce_i) begin
      if (mode_o == wic_pkg::WIC_HALT) begin
        stab_cnt <= `WIC_STAB_ZERO;
      end else if ((mode_o == wic_pkg::WIC_START) && core_tick_o) begin
        stab_cnt <= stab_cnt + `WIC_STAB_ONE;
      end
    end
  end

  // global mask flag: set by reset and service, cleared by low power and
  // return; service wins over a return in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mask_flag_o <= 1'b1;
    end else if (ce_i) begin
      if (take_now) begin
        mask_flag_o <= 1'b1;
      end else if (go_halt || go_sleep) begin
        mask_flag_o <= 1'b0;
      end else if (mode_o != wic_pkg::WIC_RUN) begin
        mask_flag_o <= 1'b0;
      end else if (return_from_handler_op_i) begin
        mask_flag_o <= 1'b0;
      end
    end
  end

  // service strobe and vector; the cpu pushes pc, x, a, cc on the strobe
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      irq_take_o <= 1'b0;
      irq_vec_o <= `WIC_VEC_RESET;
    end else if (ce_i) begin
      irq_take_o <= take_now;
      if (take_now) begin
        irq_vec_o <= pick_vec;
      end
    end
  end

  // trap latch: never masked, consumed only by its own service
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      trap_lat <= 1'b0;
    end else if (ce_i) begin
      if (trap_op_i) begin
        trap_lat <= 1'b1;
      end else if (take_now) begin
        trap_lat <= 1'b0;
      end
    end
  end

  // external latch: a new edge beats the clear from taking the vector
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ext_lat <= 1'b0;
    end else if (ce_i) begin
      if (ext_edge) begin
        ext_lat <= 1'b1;
      end else if (take_now && (pick_vec == `WIC_VEC_EXT)) begin
        ext_lat <= 1'b0;
      end
    end
  end

  // peripheral latches hold masked requests until a clear sequence;
  // peripherals other than end-suspend are frozen while halted
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      per_flag_q <= {`WIC_NPER{1'b0}};
      per_lat <= {`WIC_NPER{1'b0}};
    end else if (ce_i) begin
      per_flag_q <= per_flag_i;
      if (mode_o == wic_pkg::WIC_HALT) begin
        per_lat <= per_lat | (per_rise & `WIC_HALT_PER_MASK);
      end else begin
        per_lat <= (per_lat & ~per_clr_i) | per_rise;
      end
    end
  end

  // register writes: enable bit i serves line i+1
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      edge_line_enable_reg <= `WIC_EDGE_EN_RST;
    end else if (ce_i) begin
      if (reg_wr_i && (reg_addr_i == `WIC_OFS_EDGE_EN)) begin
        edge_line_enable_reg <= reg_wdata_i;
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= `WIC_RDATA_ZERO;
    end else if (ce_i) begin
      if (!reg_rd_i) begin
        reg_rdata_o <= `WIC_RDATA_ZERO;
      end else if (reg_addr_i == `WIC_OFS_EDGE_EN) begin
        reg_rdata_o <= edge_line_enable_reg;
      end else if (reg_addr_i == `WIC_OFS_STATUS) begin
        reg_rdata_o <= {mask_flag_o, trap_lat, ext_lat, per_lat};
      end else begin
        reg_rdata_o <= `WIC_RDATA_ZERO;
      end
    end
  end

  // checks on the sequencing, all in the one clock domain
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_halt_enter;
    ce_i && (mode_o == wic_pkg::WIC_RUN) && halt_op_i;
  endsequence

  sequence s_halted;
    !mask_flag_o && !osc_run_o && (mode_o == wic_pkg::WIC_HALT) &&
    cpu_stall_o;
  endsequence

  a_trap_unmasked:
    assert property (ce_i && trap_lat && instr_end_i && !halt_op_i &&
      !sleep_until_event_op_i && (mode_o == wic_pkg::WIC_RUN)
      |=> irq_take_o && (irq_vec_o == `WIC_VEC_TRAP))
    else $error("trap not serviced at instruction end");

  a_ext_masked:
    assert property (ce_i && mask_flag_o && !trap_lat |=> !irq_take_o)
    else $error("service taken while mask flag set");

  a_per_pending:
    assert property (ce_i && (mode_o == wic_pkg::WIC_RUN) && instr_end_i &&
      !halt_op_i && !sleep_until_event_op_i && !trap_lat && !ext_act &&
      per_lat[`WIC_SRC_TIMER] && !per_en_i[`WIC_SRC_TIMER] &&
      !(|per_act) ##1 ce_i |-> !irq_take_o && per_lat[`WIC_SRC_TIMER])
    else $error("disabled request lost or serviced");

  a_clear_drops:
    assert property (ce_i && (mode_o != wic_pkg::WIC_HALT) &&
      per_clr_i[`WIC_SRC_SCI] && !per_rise[`WIC_SRC_SCI]
      |=> !per_lat[`WIC_SRC_SCI])
    else $error("clear sequence left request latched");

  a_wait_wake:
    assert property (ce_i && (mode_o == wic_pkg::WIC_WAIT) && any_req
      |=> (mode_o == wic_pkg::WIC_RUN) && irq_take_o && !cpu_stall_o)
    else $error("wait not left on a request");

  a_halt_stays:
    assert property (ce_i && (mode_o == wic_pkg::WIC_HALT) && !halt_wake
      |=> (mode_o == wic_pkg::WIC_HALT) && !osc_run_o)
    else $error("halt left without a wake source");

  a_halt_enter:
    assert property (s_halt_enter |=> s_halted)
    else $error("halt entry did not clear mask and stop oscillator");

  a_stab_length:
    assert property ((mode_o == wic_pkg::WIC_RUN) &&
      $past(mode_o) == wic_pkg::WIC_START
      |-> $past(stab_cnt) == `WIC_STAB_LAST && irq_take_o == $past(any_req))
    else $error("start-up left before the full count");

  a_wait_enter:
    assert property (ce_i && go_sleep |=> !mask_flag_o && osc_run_o &&
      cpu_stall_o ##1 (!ce_i || !mask_flag_o || irq_take_o))
    else $error("wait entry did not force mask clear");

  a_take_masks:
    assert property (irq_take_o |-> mask_flag_o &&
      (irq_vec_o != `WIC_VEC_RESET))
    else $error("service strobe without mask set");

  a_ret_unmask:
    assert property (ce_i && return_from_handler_op_i && !take_now &&
      (mode_o == wic_pkg::WIC_RUN) |=> !mask_flag_o)
    else $error("return did not clear the mask flag");

  a_ext_consumed:
    assert property (ce_i && take_now && (pick_vec == `WIC_VEC_EXT) &&
      !ext_edge |=> !ext_lat && (irq_vec_o == `WIC_VEC_EXT))
    else $error("external latch kept after its service");
endmodule : wic_ctrl
`default_nettype wire

// File: pkg/wic_params.svh
// constants for the wake-up and interrupt control block
`ifndef WIC_PARAMS_SVH
`define WIC_PARAMS_SVH

// register map, byte offsets on the 8-bit register port
`define WIC_AW 8
`define WIC_DW 8
`define WIC_OFS_EDGE_EN 8'h08
`define WIC_OFS_STATUS 8'h0a
`define WIC_EDGE_EN_RST 8'h00
`define WIC_RDATA_ZERO 8'h00

// edge sense per line, bit 0 is line 1: lines 1,2,5,6 rise, 3,4,7,8 fall
`define WIC_RISE_MASK 8'h33

// peripheral source indices and the one peripheral allowed to end halt
`define WIC_NPER 5
`define WIC_SRC_USBES 0
`define WIC_SRC_TIMER 1
`define WIC_SRC_TWI 2
`define WIC_SRC_SCI 3
`define WIC_SRC_USB 4
`define WIC_HALT_PER_MASK 5'h01

// vector addresses (high byte address of each pair is +1)
`define WIC_VEC_RESET 16'hfffe
`define WIC_VEC_TRAP 16'hfffc
`define WIC_VEC_USBES 16'hfffa
`define WIC_VEC_EXT 16'hfff8
`define WIC_VEC_TIMER 16'hfff6
`define WIC_VEC_TWI 16'hfff4
`define WIC_VEC_SCI 16'hfff2
`define WIC_VEC_USB 16'hfff0

// core clock is the oscillator divided by 3
`define WIC_DIV_W 2
`define WIC_DIV_LAST 2'h2
`define WIC_DIV_ZERO 2'h0
`define WIC_DIV_ONE 2'h1

// oscillator stabilisation after halt, in core clock cycles
`define WIC_STAB_CYCLES 4096
`define WIC_STAB_W 12
`define WIC_STAB_LAST 12'hfff
`define WIC_STAB_ZERO 12'h000
`define WIC_STAB_ONE 12'h001

`endif

// File: pkg/wic_pkg.sv
// types shared by the wake-up and interrupt control block
`default_nettype none
package wic_pkg;
  // power mode of the core
  typedef enum logic [1:0] {
    WIC_RUN,
    WIC_WAIT,
    WIC_HALT,
    WIC_START
  } wic_mode_e;
endpackage : wic_pkg
`default_nettype wire

// File: src/wic_edge.sv
// external line synchroniser, grouping and edge detector
`include "wic_params.svh"
`default_nettype none
module wic_edge (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] dir_i,
  input wire logic [7:0] en_i,
  output logic edge_o
);
  localparam logic [7:0] RISE = `WIC_RISE_MASK;
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] act;
  logic comb;
  logic comb_q;

  // two-flop synchroniser; sync1 feeds sync2 only
  // reset to each line's idle level so that an early enable of a
  // falling line sees no false active level
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync1 <= ~RISE;
      sync2 <= ~RISE;
    end else if (ce_i) begin
      sync1 <= pin_i;
      sync2 <= sync1;
    end
  end

  // active level per line: enabled, input direction, right sense
  for (genvar i = 0; i < 8; i++) begin : g_line
    if (RISE[i]) begin : g_rise
      assign act[i] = en_i[i] & ~dir_i[i] & sync2[i];
    end else begin : g_fall
      assign act[i] = en_i[i] & ~dir_i[i] & ~sync2[i];
    end
  end

  // one vector for all lines: a line stuck active hides the others
  assign comb = |act;

  // request on the rising edge of the combined level
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      comb_q <= 1'b0;
      edge_o <= 1'b0;
    end else if (ce_i) begin
      comb_q <= comb;
      edge_o <= comb & ~comb_q;
    end
  end
endmodule : wic_edge
`default_nettype wire

// File: verif/wic_cpu_model.sv
// behavioural cpu core model facing the interrupt controller
`default_nettype none
module wic_cpu_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic slow_i,
  input wire logic kick_i,
  output logic instr_end_o,
  output logic ret_o
);
  logic [2:0] cnt;

  // instruction ends every 2nd clock, or every 6th when slow
  // return from handler one cycle after the bench asks for it
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt <= 3'h0;
      instr_end_o <= 1'b0;
      ret_o <= 1'b0;
    end else begin
      cnt <= (cnt >= (slow_i ? 3'h5 : 3'h1)) ? 3'h0 : cnt + 3'h1;
      instr_end_o <= (cnt == 3'h0);
      ret_o <= kick_i;
    end
  end
endmodule : wic_cpu_model
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the wake-up and interrupt control block
`include "wic_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rstn_i, wr_s, rd_s, trap_s, halt_s, slp_s, kick, slow;
  logic [7:0] addr, wdata, rdata, pins, dir;
  logic [4:0] pflag, pen, pclr;
  logic iend, ret, take, mask, stall, osc, tick;
  logic [15:0] vec;
  wic_pkg::wic_mode_e mode;
  int mismatches, n_compared;
  // rising lines idle low, falling lines idle high
  localparam logic [7:0] IDLE = ~`WIC_RISE_MASK;
  localparam logic [15:0] PVEC [0:4] = '{`WIC_VEC_USBES, `WIC_VEC_TIMER,
    `WIC_VEC_TWI, `WIC_VEC_SCI, `WIC_VEC_USB};

  wic_ctrl DUT (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_rdata_o(rdata), .ext_edge_line_i(pins),
    .pin_dir_i(dir), .per_flag_i(pflag), .per_en_i(pen),
    .per_clr_i(pclr), .trap_op_i(trap_s), .halt_op_i(halt_s),
    .sleep_until_event_op_i(slp_s), .return_from_handler_op_i(ret),
    .instr_end_i(iend), .irq_take_o(take), .irq_vec_o(vec),
    .mask_flag_o(mask), .cpu_stall_o(stall), .osc_run_o(osc),
    .core_tick_o(tick), .mode_o(mode));
  wic_cpu_model cpu (.clk_i(clk_i), .rstn_i(rstn_i), .slow_i(slow),
    .kick_i(kick), .instr_end_o(iend), .ret_o(ret));

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_i);
    wr_s <= 1'b0;
  endtask : wr

  // read data is sampled in the one cycle where it stands
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    @(posedge clk_i);
    check(rdata, exp);
  endtask : rdchk

  // mask may be retaken at once when a request is pending
  task automatic unmask(input bit chk);
    @(posedge clk_i);
    kick <= 1'b1;
    @(posedge clk_i);
    kick <= 1'b0;
    repeat (3) @(posedge clk_i);
    if (chk) check(mask, 1'b0);
  endtask : unmask

  task automatic wait_take(input logic [15:0] v);
    int k;
    k = 0;
    while (take !== 1'b1 && k < 40) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 40) begin
      mismatches++;
      $display("BAD t=%0t no service seen=%h exp=%h", $time, vec, v);
      give_verdict();
    end
    check(vec, v);
    check(mask, 1'b1);
  endtask : wait_take

  task automatic no_take(input int n);
    repeat (n) begin
      @(posedge clk_i);
      check(take, 1'b0);
    end
  endtask : no_take

  task automatic t_reset();
    int t;
    t = 0;
    check(mode, wic_pkg::WIC_RUN);
    check(osc, 1'b1);
    check(mask, 1'b1);
    check(vec, `WIC_VEC_RESET);
    repeat (30) begin
      @(posedge clk_i);
      t += int'(tick === 1'b1);
    end
    check(16'(t), 16'h000a);
    rdchk(`WIC_OFS_EDGE_EN, `WIC_EDGE_EN_RST);
    wr(`WIC_OFS_EDGE_EN, 8'ha5);
    wr(8'h40, 8'hff);
    wr(`WIC_OFS_STATUS, 8'hff);
    rdchk(`WIC_OFS_EDGE_EN, 8'ha5);
    rdchk(8'h40, `WIC_RDATA_ZERO);
    wr(`WIC_OFS_EDGE_EN, 8'h00);
    $display("reset and register test over");
  endtask : t_reset

  task automatic t_ext();
    for (int i = 0; i < 8; i++) begin
      slow <= i[0];
      wr(`WIC_OFS_EDGE_EN, 8'h01 << i);
      unmask(1);
      pins <= IDLE ^ (8'h01 << i);
      wait_take(`WIC_VEC_EXT);
      unmask(1);
      pins <= IDLE;
      no_take(12);
    end
    // line 1 moves while only line 2 is enabled
    wr(`WIC_OFS_EDGE_EN, 8'h02);
    pins <= IDLE ^ 8'h01;
    no_take(12);
    pins <= IDLE;
    // an output pin raises nothing
    wr(`WIC_OFS_EDGE_EN, 8'h01);
    dir <= 8'h01;
    pins <= IDLE ^ 8'h01;
    no_take(12);
    pins <= IDLE;
    wr(`WIC_OFS_EDGE_EN, 8'h03);
    // pins stay digital inputs with no alternate function
    dir <= 8'h00;
    // line 1 held active hides a later edge on line 2
    pins <= IDLE ^ 8'h01;
    wait_take(`WIC_VEC_EXT);
    @(posedge clk_i);
    trap_s <= 1'b1;
    @(posedge clk_i);
    trap_s <= 1'b0;
    wait_take(`WIC_VEC_TRAP);
    unmask(1);
    pins <= IDLE ^ 8'h03;
    no_take(12);
    pins <= IDLE;
    $display("external line test over");
  endtask : t_ext

  task automatic t_per();
    pflag <= 5'h02;
    no_take(12);
    rdchk(`WIC_OFS_STATUS, 8'h02);
    pen <= 5'h02;
    wait_take(`WIC_VEC_TIMER);
    pclr <= 5'h02;
    pflag <= 5'h00;
    @(posedge clk_i);
    pclr <= 5'h00;
    unmask(1);
    // a disabled pending request is lost by the clear
    pen <= 5'h00;
    pflag <= 5'h08;
    repeat (2) @(posedge clk_i);
    pclr <= 5'h08;
    @(posedge clk_i);
    pclr <= 5'h00;
    pflag <= 5'h00;
    pen <= 5'h1f;
    no_take(12);
    pflag <= 5'h1f;
    for (int i = 0; i < 5; i++) begin
      wait_take(PVEC[i]);
      pclr <= 5'h01 << i;
      @(posedge clk_i);
      pclr <= 5'h00;
      unmask(0);
    end
    pflag <= 5'h00;
    no_take(12);
    $display("peripheral test over");
  endtask : t_per

  task automatic t_wait();
    slp_s <= 1'b1;
    @(posedge clk_i);
    slp_s <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(mode, wic_pkg::WIC_WAIT);
    check(mask, 1'b0);
    check(stall, 1'b1);
    pflag <= 5'h10;
    wait_take(`WIC_VEC_USB);
    check(mode, wic_pkg::WIC_RUN);
    pclr <= 5'h10;
    pflag <= 5'h00;
    @(posedge clk_i);
    pclr <= 5'h00;
    unmask(1);
    $display("wait test over");
  endtask : t_wait

  task automatic t_halt();
    int k;
    int t;
    k = 0;
    t = 0;
    wr(`WIC_OFS_EDGE_EN, 8'h01);
    halt_s <= 1'b1;
    @(posedge clk_i);
    halt_s <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(mode, wic_pkg::WIC_HALT);
    check(mask, 1'b0);
    check(osc, 1'b0);
    pflag <= 5'h02;
    no_take(20);
    check(mode, wic_pkg::WIC_HALT);
    pflag <= 5'h00;
    pins <= IDLE ^ 8'h01;
    // count core ticks of the start-up delay
    while (take !== 1'b1 && k < 20000) begin
      @(posedge clk_i);
      k++;
      if (tick === 1'b1 && mode === wic_pkg::WIC_START) t++;
    end
    check(16'(t), 16'(`WIC_STAB_CYCLES));
    wait_take(`WIC_VEC_EXT);
    check(mode, wic_pkg::WIC_RUN);
    pins <= IDLE;
    unmask(1);
    no_take(12);
    $display("halt test over");
  endtask : t_halt

  // reset for two cycles, then the scenarios in turn
  initial begin
    rstn_i = 1'b0;
    {wr_s, rd_s, trap_s, halt_s, slp_s, kick, slow} = 7'h00;
    {addr, wdata, dir} = 24'h000000;
    {pflag, pen, pclr} = 15'h0000;
    pins = IDLE;
    mismatches = 0;
    n_compared = 0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_ext();
    t_per();
    t_wait();
    t_halt();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
